// *** core/i2cmb_stop_port.sv ***
// two-wire/spi master port: baud generation and stop-collision check
//
// How it works
// - stop drives sda low, then releases scl
// - scl high reloads counter, counts to zero
// - sda still low after expiry is collision
// - scl low before sda rises is collision
// - one counter times both master modes
// - spi buffer write starts counter from reload
// - counter stops after operation, clock holds
// - reload copies register twice per period
// - bus clock is osc over 8(reload+1)
// - collision sets flag, port goes idle
// - collision aborts stop, releases, clears request
// - good stop sets stop-seen then event
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/100ps
module i2cmb_stop_port
    import i2cmbs_pkg::*;
#(
    parameter int RELOAD_WIDTH = 8
) (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    input wire logic SCL_IN,
    output logic SCL_OUT,
    output logic SCL_OE,
    output logic SCK_OUT,
    output logic IRQ
);
    logic [RELOAD_WIDTH-1:0] baud_reload_register;
    logic [7:0] serial_data_buffer;
    logic [7:0] port_control_one;
    logic stop_request;
    logic stop_seen;
    logic [1:0] irq_status;
    logic [1:0] irq_enable;
    i2cmb_stop_type state;
    logic tick;
    logic expired;
    logic reload;
    logic run;
    logic spi_run;
    logic collision;
    logic stop_done;
    logic sda_low;
    logic scl_low;
    logic wr;
    logic rd;
    logic [3:0] mode;

    assign mode = port_control_one[CTRL_ONE_MODE_LSB +: 4];
    assign wr = PSEL && PENABLE && PWRITE;
    assign rd = PSEL && !PWRITE;

    i2cmb_quarter u_quarter (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .tick(tick)
    );

    i2cmb_baud_counter #(.WIDTH(RELOAD_WIDTH)) u_counter (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .tick(tick),
        .run(run),
        .reload(reload),
        .reload_value(baud_reload_register),
        .expired(expired)
    );

    function automatic logic is_addr(input logic [7:0] a, input logic [7:0] b);
        return a == b;
    endfunction

    // apb answers in the access cycle; offsets above the irq clear register raise pslverr
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= PSEL && !PENABLE;
            PSLVERR <= PSEL && !PENABLE && PADDR > ADDR_IRQ_CLEAR;
        end
    end

    // read data latched in the setup cycle, stable through access
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            PRDATA <= ZERO_WORD;
        end else if (rd && !PENABLE) begin
            PRDATA <= ZERO_WORD;
            if (is_addr(PADDR, ADDR_RELOAD))
                PRDATA[RELOAD_WIDTH-1:0] <= baud_reload_register;
            if (is_addr(PADDR, ADDR_BUFFER))
                PRDATA[7:0] <= serial_data_buffer;
            if (is_addr(PADDR, ADDR_CTRL_ONE))
                PRDATA[7:0] <= port_control_one;
            if (is_addr(PADDR, ADDR_CTRL_TWO))
                PRDATA[CTRL_TWO_STOP] <= stop_request;
            if (is_addr(PADDR, ADDR_STATUS))
                PRDATA[STATUS_STOP_SEEN] <= stop_seen;
            if (is_addr(PADDR, ADDR_IRQ_STATUS))
                PRDATA[1:0] <= irq_status;
            if (is_addr(PADDR, ADDR_IRQ_ENABLE))
                PRDATA[1:0] <= irq_enable;
        end
    end

    // configuration; write collision flag set by hardware, cleared by sw
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            baud_reload_register <= RELOAD_RESET;
            port_control_one <= 8'h00;
            irq_enable <= 2'h0;
        end else if (wr) begin
            if (is_addr(PADDR, ADDR_RELOAD))
                baud_reload_register <= PWDATA[RELOAD_WIDTH-1:0];
            if (is_addr(PADDR, ADDR_CTRL_ONE))
                port_control_one <= PWDATA[7:0];
            if (is_addr(PADDR, ADDR_IRQ_ENABLE))
                irq_enable <= PWDATA[1:0];
            // a buffer write while a stop runs is refused and flagged
            if (is_addr(PADDR, ADDR_BUFFER) && state != I2CMB_IDLE)
                port_control_one[CTRL_ONE_WRITE_CLASH] <= 1'b1;
        end
    end

    // buffer write is dropped while a stop sequence is busy
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            serial_data_buffer <= 8'h00;
        end else if (wr && is_addr(PADDR, ADDR_BUFFER)
                     && state == I2CMB_IDLE) begin
            serial_data_buffer <= PWDATA[7:0];
        end
    end

    // spi master clock: buffer write starts it, sixteen phases finish it
    logic [4:0] spi_phases;
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            spi_phases <= 5'h00;
            SCK_OUT <= 1'b0;
        end else if (mode != MODE_SPI_MASTER || !port_control_one[CTRL_ONE_EN]) begin
            spi_phases <= 5'h00;
        end else if (wr && is_addr(PADDR, ADDR_BUFFER)) begin
            spi_phases <= SPI_PHASE_COUNT;
        end else if (expired && spi_phases != 5'h00) begin
            spi_phases <= spi_phases - 5'h01;
            SCK_OUT <= !SCK_OUT;
        end
    end
    // when phases run out the clock pin keeps its last level
    assign spi_run = spi_phases != 5'h00;

    // one counter serves both modes; reload at start and each rollover but the last of a stop
    assign run = spi_run || (state == I2CMB_SCL_HIGH)
                 || (state == I2CMB_SDA_UP) || (state == I2CMB_FINISH);
    assign reload = (wr && is_addr(PADDR, ADDR_BUFFER)
                     && mode == MODE_SPI_MASTER)
                    || (expired && spi_run)
                    || (expired && (state == I2CMB_SCL_HIGH
                                    || state == I2CMB_SDA_UP))
                    || (state == I2CMB_RELEASE_SCL && SCL_IN);
    assign sda_low = !SDA_IN;
    assign scl_low = !SCL_IN;

    // stop sequence with collision watch
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state <= I2CMB_IDLE;
            SDA_OE <= 1'b0;
            SCL_OE <= 1'b0;
            collision <= 1'b0;
            stop_done <= 1'b0;
        end else begin
            collision <= 1'b0;
            stop_done <= 1'b0;
            unique case (state)
                I2CMB_IDLE: begin
                    // request is still set the cycle after a collision
                    if (stop_request && !collision
                        && mode == MODE_I2C_MASTER) begin
                        state <= I2CMB_DRIVE_LOW;
                        SDA_OE <= 1'b1;
                        SCL_OE <= 1'b1;
                    end
                end
                I2CMB_DRIVE_LOW: begin
                    if (sda_low) begin
                        SCL_OE <= 1'b0;
                        state <= I2CMB_RELEASE_SCL;
                    end
                end
                I2CMB_RELEASE_SCL: begin
                    if (SCL_IN)
                        state <= I2CMB_SCL_HIGH;
                end
                I2CMB_SCL_HIGH: begin
                    if (scl_low) begin
                        collision <= 1'b1;
                        state <= I2CMB_IDLE;
                        SDA_OE <= 1'b0;
                    end else if (expired) begin
                        SDA_OE <= 1'b0;
                        state <= I2CMB_SDA_UP;
                    end
                end
                I2CMB_SDA_UP: begin
                    if (expired && sda_low) begin
                        collision <= 1'b1;
                        state <= I2CMB_IDLE;
                    end else if (scl_low && sda_low) begin
                        collision <= 1'b1;
                        state <= I2CMB_IDLE;
                    end else if (expired) begin
                        stop_done <= 1'b1;
                        state <= I2CMB_FINISH;
                    end
                end
                I2CMB_FINISH: begin
                    if (expired)
                        state <= I2CMB_IDLE;
                end
                default: state <= I2CMB_IDLE;
            endcase
        end
    end

    // each stop phase but the last reloads on expiry and lasts a full counter period;
    // the first may be up to three clocks short, as the tick runs free

    // stop request: sw sets, hw clears at finish or collision
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            stop_request <= 1'b0;
        end else if (collision) begin
            stop_request <= 1'b0;
        end else if (state == I2CMB_FINISH && expired) begin
            stop_request <= 1'b0;
        end else if (wr && is_addr(PADDR, ADDR_CTRL_TWO)
                     && PWDATA[CTRL_TWO_STOP]) begin
            stop_request <= 1'b1;
        end
    end

    // stop-seen bit cleared when the port is disabled or a new stop starts
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            stop_seen <= 1'b0;
        end else if (stop_done) begin
            stop_seen <= 1'b1;
        end else if (!port_control_one[CTRL_ONE_EN]
                     || state == I2CMB_DRIVE_LOW) begin
            stop_seen <= 1'b0;
        end
    end

    // sticky interrupt status; set beats a clear in the same cycle
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            irq_status <= 2'h0;
        end else begin
            if (wr && is_addr(PADDR, ADDR_IRQ_CLEAR))
                irq_status <= irq_status & ~PWDATA[1:0]
                              | {collision, state == I2CMB_FINISH && expired};
            else begin
                if (collision)
                    irq_status[IRQ_COLLISION] <= 1'b1;
                if (state == I2CMB_FINISH && expired)
                    irq_status[IRQ_PORT_EVENT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N)
            IRQ <= 1'b0;
        else
            IRQ <= |(irq_status & irq_enable);
    end

    // open-drain: only ever drive low
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            SDA_OUT <= 1'b0;
            SCL_OUT <= 1'b0;
        end else begin
            SDA_OUT <= 1'b0;
            SCL_OUT <= 1'b0;
        end
    end

    // sda released (oe low) yet low at counter expiry must flag collision
    chk_stop_sda_collision: assert property (
        @(posedge SYS_CLK) disable iff (!RST_N)
        (state == I2CMB_SDA_UP && expired && sda_low) |=> collision)
        else $error("sda low after expiry not flagged");
    chk_stop_scl_collision: assert property (
        @(posedge SYS_CLK) disable iff (!RST_N)
        (state == I2CMB_SCL_HIGH && scl_low) |=> collision && !SDA_OE)
        else $error("scl low before sda rise not flagged");
    chk_scl_release_order: assert property (
        @(posedge SYS_CLK) disable iff (!RST_N)
        $fell(SCL_OE) |-> $past(state) == I2CMB_DRIVE_LOW && SDA_OE)
        else $error("scl released before sda low");
    chk_collision_idle: assert property (
        @(posedge SYS_CLK) disable iff (!RST_N)
        collision |-> state == I2CMB_IDLE ##1 irq_status[IRQ_COLLISION])
        else $error("collision did not idle or flag");
    chk_collision_abort: assert property (
        @(posedge SYS_CLK) disable iff (!RST_N)
        collision |=> !stop_request && !SDA_OE && !SCL_OE)
        else $error("collision did not abort stop");
    chk_stop_seen_set: assert property (
        @(posedge SYS_CLK) disable iff (!RST_N)
        stop_done |=> stop_seen && state == I2CMB_FINISH)
        else $error("stop completion not reported");
    chk_stop_event_set: assert property (
        @(posedge SYS_CLK) disable iff (!RST_N)
        (state == I2CMB_FINISH && expired)
        |=> irq_status[IRQ_PORT_EVENT] && !stop_request)
        else $error("stop end did not raise event");
    chk_collision_stays_idle: assert property (
        @(posedge SYS_CLK) disable iff (!RST_N)
        collision |=> state == I2CMB_IDLE && !SDA_OE)
        else $error("stop restarted after collision");
    chk_reload_scl_high: assert property (
        @(posedge SYS_CLK) disable iff (!RST_N)
        (state == I2CMB_RELEASE_SCL && SCL_IN)
        |=> u_counter.count == baud_reload_register)
        else $error("no reload when scl high");
    chk_tick_rate: assert property (
        @(posedge SYS_CLK) disable iff (!RST_N)
        tick |=> !tick ##1 !tick ##1 !tick ##1 tick)
        else $error("counter step rate not one in four");
endmodule

// *** core/i2cmbs_pkg.sv ***
// constants and types shared by the stop-collision port logic
package i2cmbs_pkg;
    // register byte offsets on the apb bus
    localparam logic [7:0] ADDR_RELOAD = 8'h00;
    localparam logic [7:0] ADDR_BUFFER = 8'h04;
    localparam logic [7:0] ADDR_CTRL_ONE = 8'h08;
    localparam logic [7:0] ADDR_CTRL_TWO = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h18;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h1C;
    // field positions
    localparam int CTRL_ONE_WRITE_CLASH = 7;
    localparam int CTRL_ONE_EN = 5;
    localparam int CTRL_ONE_MODE_LSB = 0;
    localparam int CTRL_TWO_STOP = 2;
    localparam int STATUS_STOP_SEEN = 4;
    localparam int IRQ_PORT_EVENT = 0;
    localparam int IRQ_COLLISION = 1;
    // mode codes: two-wire master and spi master in control one bits 3:0
    localparam logic [3:0] MODE_I2C_MASTER = 4'h8;
    localparam logic [3:0] MODE_SPI_MASTER = 4'hA;
    localparam logic [7:0] RELOAD_RESET = 8'h00;
    localparam logic [1:0] QUARTER_LAST = 2'h3;
    // spi clock phases per byte: two per bit
    localparam logic [4:0] SPI_PHASE_COUNT = 5'h10;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    // stop sequence states
    typedef enum logic [2:0] {
        I2CMB_IDLE,
        I2CMB_DRIVE_LOW,
        I2CMB_RELEASE_SCL,
        I2CMB_SCL_HIGH,
        I2CMB_SDA_UP,
        I2CMB_FINISH
    } i2cmb_stop_type;
endpackage

// *** core/i2cmb_quarter.sv ***
// one-cycle enable at a quarter of the system clock (instruction rate)
`timescale 1ns/100ps
module i2cmb_quarter
    import i2cmbs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    output logic tick
);
    logic [1:0] count;

    // free-running divide by four; tick on the last phase
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= 2'h0;
            tick <= 1'b0;
        end else begin
            count <= count + 2'h1;
            tick <= (count == QUARTER_LAST - 2'h1);
        end
    end
endmodule

// *** core/i2cmb_baud_counter.sv ***
// reloadable down-counter giving the bus clock phase length
`timescale 1ns/100ps
module i2cmb_baud_counter
    import i2cmbs_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic run,
    input wire logic reload,
    input wire logic [WIDTH-1:0] reload_value,
    output logic expired
);
    logic [WIDTH-1:0] count;

    // load wins over counting; hold when not running
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else if (reload) begin
            count <= reload_value;
        end else if (run && tick && count != '0) begin
            count <= count - 1'b1;
        end
    end

    // expiry must not look at reload: reload is built from expiry outside
    assign expired = run && tick && (count == '0);
endmodule

// *** bench/i2cmb_bus_model.sv ***
// shared open-drain bus with pull-ups and another master on it
`timescale 1ns/100ps
module i2cmb_bus_model (
    input wire logic sda_oe,
    input wire logic scl_oe,
    input wire logic hold_sda,
    input wire logic hold_scl,
    output logic sda,
    output logic scl
);
    // pull-ups win unless a party pulls low, so no stale level remains
    assign sda = !(sda_oe || hold_sda);
    assign scl = !(scl_oe || hold_scl);
endmodule

// *** bench/i2c_master_baud_stop_collision_test.sv ***
// self-checking bench for the stop-collision and baud counter port
`timescale 1ns/100ps
module i2c_master_baud_stop_collision_test
    import i2cmbs_pkg::*;
;
    logic sys_clk, rst_n, psel, penable, pwrite, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, sda, scl, sda_out, sda_oe, scl_out, scl_oe;
    logic sck, last_sck, irq, hold_sda, hold_scl;
    int n_fail, checks_done, n, gap, toggles, bad_gap;

    // free-running system clock
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    i2cmb_stop_port dut_u (.SYS_CLK(sys_clk), .RST_N(rst_n), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .SDA_IN(sda),
        .SDA_OUT(sda_out), .SDA_OE(sda_oe), .SCL_IN(scl), .SCL_OUT(scl_out),
        .SCL_OE(scl_oe), .SCK_OUT(sck), .IRQ(irq));
    i2cmb_bus_model bus_u (.sda_oe(sda_oe), .scl_oe(scl_oe),
        .hold_sda(hold_sda), .hold_scl(hold_scl), .sda(sda), .scl(scl));

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask

    task close_out;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task bound_hit;
        n_fail++;
        $display("BAD t=%0t wait ran out", $time);
        close_out();
    endtask

    // one apb transfer; request held until pready is seen high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge sys_clk);
            if (pready === 1'b1)
                break;
        end
        if (i == 20)
            bound_hit();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, ZERO_WORD);
        chk(rd, exp);
    endtask

    // polls the sticky status until the given bit shows up
    task wait_irq(input int b);
        int i;
        for (i = 0; i < 400; i++) begin
            apb(1'b0, ADDR_IRQ_STATUS, ZERO_WORD);
            if (rd[b] === 1'b1)
                break;
        end
        if (i == 400)
            bound_hit();
    endtask

    // the stop has to start (sda driven) before scl can be let go
    task wait_scl_free;
        n = 0;
        while (n < 200 && sda_oe !== 1'b1) begin
            @(posedge sys_clk);
            n++;
        end
        while (n < 200 && scl_oe !== 1'b0) begin
            @(posedge sys_clk);
            n++;
        end
        if (n == 200)
            bound_hit();
    endtask

    task t_reset;
        rdchk(ADDR_RELOAD, 32'h0000_0000);
        rdchk(ADDR_STATUS, 32'h0000_0000);
        rdchk(ADDR_IRQ_STATUS, 32'h0000_0000);
        chk(irq, 1'b0);
        apb(1'b0, 8'h20, ZERO_WORD);
        chk(err, 1'b1);
        $display("done reset and decode");
    endtask

    task t_stop;
        wr(ADDR_RELOAD, 32'h0000_0003);
        wr(ADDR_CTRL_ONE, 32'h0000_0028);
        wr(ADDR_IRQ_ENABLE, 32'h0000_0003);
        wr(ADDR_CTRL_TWO, 32'h0000_0004);
        wait_scl_free();
        chk(sda_oe, 1'b1);
        // sda let go one period after scl: 13..16 clocks by tick phase,
        // seen here one edge later
        for (n = 0; n < 200 && sda_oe !== 1'b0; n++)
            @(posedge sys_clk);
        chk(n >= 14 && n <= 17, 1'b1);
        wr(ADDR_BUFFER, 32'h0000_005A);
        rdchk(ADDR_CTRL_ONE, 32'h0000_00A8);
        wait_irq(IRQ_PORT_EVENT);
        rdchk(ADDR_IRQ_STATUS, 32'h0000_0001);
        rdchk(ADDR_STATUS, 32'h0000_0010);
        rdchk(ADDR_CTRL_TWO, 32'h0000_0000);
        chk(irq, 1'b1);
        wr(ADDR_IRQ_CLEAR, 32'h0000_0001);
        rdchk(ADDR_IRQ_STATUS, 32'h0000_0000);
        chk(irq, 1'b0);
        $display("done good stop");
    endtask

    // another master keeps sda low through the stop
    task t_coll_sda;
        wr(ADDR_CTRL_ONE, 32'h0000_0028);
        wr(ADDR_IRQ_ENABLE, 32'h0000_0001);
        hold_sda <= 1'b1;
        wr(ADDR_CTRL_TWO, 32'h0000_0004);
        wait_irq(IRQ_COLLISION);
        chk(irq, 1'b0);
        rdchk(ADDR_CTRL_TWO, 32'h0000_0000);
        chk({sda_oe, scl_oe}, 2'h0);
        rdchk(ADDR_IRQ_STATUS, 32'h0000_0002);
        rdchk(ADDR_STATUS, 32'h0000_0000);
        chk({sda_out, scl_out}, 2'h0);
        wr(ADDR_IRQ_ENABLE, 32'h0000_0002);
        repeat (2) @(posedge sys_clk);
        chk(irq, 1'b1);
        hold_sda <= 1'b0;
        wr(ADDR_IRQ_CLEAR, 32'h0000_0002);
        rdchk(ADDR_IRQ_STATUS, 32'h0000_0000);
        chk(irq, 1'b0);
        $display("done sda collision");
    endtask

    // another master pulls scl low before sda has risen
    task t_coll_scl;
        wr(ADDR_CTRL_TWO, 32'h0000_0004);
        wait_scl_free();
        repeat (3) @(posedge sys_clk);
        hold_scl <= 1'b1;
        wait_irq(IRQ_COLLISION);
        rdchk(ADDR_IRQ_STATUS, 32'h0000_0002);
        rdchk(ADDR_CTRL_TWO, 32'h0000_0000);
        chk(sda_oe, 1'b0);
        hold_scl <= 1'b0;
        wr(ADDR_IRQ_CLEAR, 32'h0000_0003);
        $display("done scl collision");
    endtask

    // spi phases come from the same counter and stop after the byte
    task t_spi;
        wr(ADDR_CTRL_ONE, 32'h0000_002A);
        wr(ADDR_BUFFER, 32'h0000_00A5);
        last_sck = sck;
        gap = 0;
        toggles = 0;
        bad_gap = 0;
        repeat (900) begin
            @(posedge sys_clk);
            gap++;
            if (sck !== last_sck) begin
                if (toggles > 0 && (gap < 16 || gap > 20))
                    bad_gap++;
                toggles++;
                gap = 0;
                last_sck = sck;
            end
        end
        chk(bad_gap, 0);
        chk(toggles, 16);
        $display("done spi clock");
    endtask

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = ZERO_WORD;
        hold_sda = 1'b0;
        hold_scl = 1'b0;
        rst_n = 1'b0;
        n_fail = 0;
        checks_done = 0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset();
        t_stop();
        t_coll_sda();
        t_coll_scl();
        t_spi();
        close_out();
    end
endmodule
